// [pkg/bcu_cfg_pkg.sv]
// Constants for the bus timing, refresh and configuration register bank.
// Assumes a 16-bit register port with full 32-bit physical addresses.
package bcu_cfg_pkg;
	// ----------------------------------------
	// Register addresses
	// ----------------------------------------
	localparam logic [31:0] ADDR_ACCESS_WAIT   = 32'h0B00000A;
	localparam logic [31:0] ADDR_BUS_ERROR     = 32'h0B00000C;
	localparam logic [31:0] ADDR_REFRESH_INT   = 32'h0B00000E;
	localparam logic [31:0] ADDR_REVISION      = 32'h0B000010;
	localparam logic [31:0] ADDR_REFRESH_CNT   = 32'h0B000012;
	localparam logic [31:0] ADDR_CLOCK_RATIO   = 32'h0B000014;
	localparam logic [31:0] ADDR_EXPANSION_CFG = 32'h0B000016;

	// ----------------------------------------
	// Widths and field positions
	// ----------------------------------------
	localparam int DATA_W      = 16;
	localparam int RFSH_W      = 14;
	localparam int WAIT_W      = 4;
	localparam int PROM_LSB    = 12;
	localparam int WIN_LSB     = 8;
	localparam int SYS_LSB     = 4;
	localparam int ROM_LSB     = 0;
	localparam int ERR_BIT     = 0;
	localparam int EROM_BIT    = 15;
	localparam int EDRAM_BIT   = 14;
	localparam int BMAP_LSB    = 12;
	localparam int EMEM_BIT    = 11;
	localparam int LCD_BUS_WIDTH_BIT   = 7;
	localparam int ID_LSB      = 12;
	localparam int MJ_LSB      = 8;
	localparam int MN_LSB      = 0;
	localparam int DIV2_BIT    = 15;
	localparam int DIV3_BIT    = 14;
	localparam int DIV4_BIT    = 13;
	localparam int CLOCK_SPEED_CODE_LSB   = 0;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [RFSH_W-1:0] INTERVAL_RST = 14'h0200;
	localparam logic [RFSH_W-1:0] COUNT_RST    = 14'h0001;

	// ----------------------------------------
	// Wait code decode: cycles = base - step * code
	// ----------------------------------------
	localparam int PROM_BASE = 3;
	localparam int PROM_STEP = 1;
	localparam int PROM_MAX  = 2;
	localparam int LCD_BASE  = 8;
	localparam int LCD_STEP  = 2;
	localparam int LCD_MAX   = 3;
	localparam int FMEM_BASE = 8;
	localparam int FMEM_STEP = 1;
	localparam int FMEM_MAX  = 7;
	localparam int SYS_BASE  = 8;
	localparam int SYS_STEP  = 1;
	localparam int SYS_MAX   = 5;
	localparam int ROM_BASE  = 9;
	localparam int ROM_STEP  = 1;
	localparam int ROM_MAX   = 7;

	// ----------------------------------------
	// Bank map codes and bus widths
	// ----------------------------------------
	localparam logic [1:0] BMAP_ALL_ROM  = 2'h3;
	localparam logic [1:0] BMAP_HI_ROM   = 2'h2;
	localparam logic [1:0] BMAP_ALL_DRAM = 2'h0;
	localparam logic [5:0] WIDTH_WIDE    = 6'h20;
	localparam logic [5:0] WIDTH_NARROW  = 6'h10;

	// ----------------------------------------
	// Clock ratios, scaled by three to keep 21.33 whole
	// ----------------------------------------
	localparam logic [6:0] MULT_X3_DIV2 = 7'h60;
	localparam logic [6:0] MULT_X3_DIV3 = 7'h40;
	localparam logic [6:0] MULT_X3_DIV4 = 7'h30;
	localparam logic [6:0] MULT_X3_NONE = 7'h00;
	localparam logic [6:0] CORE_MULT    = 7'h40;
	localparam int         REF_CLK_KHZ  = 18432;
endpackage

// [core/wait_decode.sv]
// Turns a wait code into a registered count of peripheral clocks.
// Assumes the code comes from a register on the same clock.
`timescale 1ns/1ps
`default_nettype none
module wait_decode #(
	parameter int W    = 3,
	parameter int BASE = 8,
	parameter int STEP = 1,
	parameter int MAXC = 7
) (
	// Clock and reset
	input  wire logic                            clock,
	input  wire logic                            rst,
	// Code in, cycles out
	input  wire logic [W-1:0]                    code,
	output logic      [bcu_cfg_pkg::WAIT_W-1:0] cycles,
	output logic                                 valid
);
	import bcu_cfg_pkg::*;

	typedef struct packed {
		logic [WAIT_W-1:0] cycles;
		logic              valid;
	} dec_s;

	dec_s st_ff, nxt_st;

	// Reserved codes report zero cycles and drop valid
	always_comb begin
		nxt_st = st_ff;
		nxt_st.valid = (int'(code) <= MAXC);
		nxt_st.cycles = nxt_st.valid ? WAIT_W'(BASE - STEP * int'(code)) : '0;
	end

	// State register
	always_ff @(posedge clock) begin
		if (rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign cycles = st_ff.cycles;
	assign valid  = st_ff.valid;
endmodule
`default_nettype wire

// [core/refresh_counter.sv]
// Down counter for DRAM refresh with reload and bus timeout detection.
// Assumes occupancy and completion inputs are on the same clock.
`timescale 1ns/1ps
`default_nettype none
module refresh_counter (
	// Clock and reset
	input  wire logic                            clock,
	input  wire logic                            rst,
	// Interval and software load
	input  wire logic [bcu_cfg_pkg::RFSH_W-1:0] interval,
	input  wire logic                            load_en,
	input  wire logic [bcu_cfg_pkg::RFSH_W-1:0] load_value,
	// Bus side
	input  wire logic                            refresh_done,
	input  wire logic                            bus_occupied,
	output logic      [bcu_cfg_pkg::RFSH_W-1:0] count,
	output logic                                 refresh_request,
	output logic                                 refresh_pending,
	output logic                                 bus_timeout
);
	import bcu_cfg_pkg::*;

	typedef struct packed {
		logic [RFSH_W-1:0] count;
		logic              pending;
	} rfc_s;

	rfc_s st_ff, nxt_st;

	always_comb begin
		nxt_st = st_ff;
		// [R10] Zero reloads
		// [R11] Counts regardless of service
		if (load_en) begin
			nxt_st.count = load_value;
		end else if (st_ff.count == '0) begin
			nxt_st.count = interval;
		end else begin
			nxt_st.count = st_ff.count - RFSH_W'(1);
		end
		// [R13] Lost refresh replaced
		nxt_st.pending = refresh_request | (st_ff.pending & ~refresh_done);
	end

	// State register
	always_ff @(posedge clock) begin
		if (rst) begin
			st_ff.count   <= COUNT_RST;
			st_ff.pending <= 1'b0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign count           = st_ff.count;
	assign refresh_pending = st_ff.pending;
	assign refresh_request = (st_ff.count == '0);
	// [R12] Unserved request times out
	assign bus_timeout     = refresh_request & st_ff.pending & ~refresh_done & bus_occupied;
endmodule
`default_nettype wire

// [core/bus_timing_refresh_config_regs.sv]
// Register bank for bus wait timing, bus error status, refresh and expansion setup.
// Assumes a one-cycle strobe register port and same-clock bus status inputs;
// the wide bus mode pin and clock straps arrive asynchronously.
//
// What this block does
// [R1] Page ROM code 10,01,00 gives 1,2,3 clocks; 11 reserved.
// [R2] Window code gives 2..8 clocks for LCD, 1..8 for fast memory.
// [R3] System bus code 101..000 gives 3..8 clocks; 110,111 reserved.
// [R4] ROM code 111..000 gives 2..9 clocks.
// [R5] Page ROM wait applies only to banks with page ROM enabled.
// [R6] Reserved bits read zero; software writes zero.
// [R7] Error flag reads one after a bus error; writing one clears it.
// [R8] Every bus error request sets the error flag.
// [R9] Fourteen-bit interval holds refresh period in peripheral clocks.
// [R10] Counter at zero requests refresh and reloads from interval.
// [R11] Counter keeps running whether or not refresh happened.
// [R12] Unserved request at next zero while bus occupied is a timeout.
// [R13] A timeout costs exactly one refresh cycle.
// [R14] Revision register shows id, major and minor fields.
// [R15] Software must not characterise parts by revision numbers.
// [R16] Peripheral clock multiplier chosen by whichever divider flag is zero.
// [R17] Core clock is reference over speed code times 64.
// [R18] Size bits select 64 or 32 Mbit ROM, 64 or 16 Mbit DRAM.
// [R19] Bank map: 11 all ROM, 10 upper ROM, 00 all DRAM.
// [R20] Expansion memory access allowed only while its enable is set.
// [R21] LCD bus 32 or 16 bits; fast memory stays 16 bits.
// [R22] Expansion register writable only in wide bus mode.
// [R23] Window select steers window to fast memory or LCD.
// [R24] Page ROM enable picks page ROM or ordinary ROM per bank.
// [R25] Hold timeout enable gates timeout detection during bus hold.
// [R26] A new error beats a simultaneous clear.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module bus_timing_refresh_config_regs #(
	// Arbitrary identification values
	parameter logic [3:0] PROCESSOR_ID = 4'h5,
	parameter logic [3:0] MAJOR_REV    = 4'h1,
	parameter logic [3:0] MINOR_REV    = 4'h0
) (
	// Clock and reset
	input  wire logic                                  clock,
	input  wire logic                                  rst,
	// Register port
	input  wire logic [31:0]                           reg_addr,
	input  wire logic [bcu_cfg_pkg::DATA_W-1:0]       reg_wdata,
	input  wire logic                                  reg_wr,
	input  wire logic                                  reg_rd,
	output logic      [bcu_cfg_pkg::DATA_W-1:0]       reg_rdata,
	// Bus status from the cycle generator
	input  wire logic                                  bus_error_event,
	input  wire logic                                  sysbus_busy,
	input  wire logic                                  window_busy,
	input  wire logic                                  hold_active,
	input  wire logic                                  refresh_done,
	// Mode bits from other control registers
	input  wire logic                                  window_select,
	input  wire logic [1:0]                            page_rom_enable,
	input  wire logic                                  hold_timeout_enable,
	// Pins and clock straps
	input  wire logic                                  wide_bus_mode,
	input  wire logic [4:0]                            clock_speed_code,
	input  wire logic                                  divide_by_two_flag,
	input  wire logic                                  divide_by_three_flag,
	input  wire logic                                  divide_by_four_flag,
	// Wait counts
	output logic      [bcu_cfg_pkg::WAIT_W-1:0]       rom_bank0_wait,
	output logic      [bcu_cfg_pkg::WAIT_W-1:0]       rom_bank1_wait,
	output logic      [bcu_cfg_pkg::WAIT_W-1:0]       window_wait_cycles,
	output logic      [bcu_cfg_pkg::WAIT_W-1:0]       sysbus_wait_cycles,
	output logic                                       wait_codes_valid,
	// Refresh and errors
	output logic                                       refresh_request,
	output logic                                       bus_timeout,
	output logic                                       bus_error_flag,
	// Expansion and widths
	output logic                                       expansion_rom_size,
	output logic                                       expansion_dram_size,
	output logic                                       bank3_is_rom,
	output logic                                       bank2_is_rom,
	output logic                                       bank_map_valid,
	output logic                                       expansion_access_allowed,
	output logic      [5:0]                            window_data_width,
	// Clock ratios
	output logic      [6:0]                            peripheral_clock_mult_x3,
	output logic      [6:0]                            core_clock_mult
);
	import bcu_cfg_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [1:0]        page_rom_wait;
		logic [2:0]        window_wait;
		logic [2:0]        sysbus_wait;
		logic [2:0]        rom_wait;
		logic              bus_error_flag;
		logic [RFSH_W-1:0] interval;
		logic              exp_rom_size;
		logic              exp_dram_size;
		logic [1:0]        bank_map;
		logic              exp_enable;
		logic              lcd_bus_width;
		logic [DATA_W-1:0] rdata;
		logic [8:0]        pin_s1;
		logic [8:0]        pin_s2;
		logic [6:0]        pclk_mult;
	} regs_s;

	regs_s st_ff, nxt_st;

	logic [RFSH_W-1:0] refresh_count;
	logic              refresh_pending;
	logic              bus_occupied;
	logic              wide_sync;
	logic              wr_cnt;
	logic [WAIT_W-1:0] prom_cyc;
	logic [WAIT_W-1:0] lcd_cyc;
	logic [WAIT_W-1:0] fmem_cyc;
	logic [WAIT_W-1:0] rom_cyc;
	logic              prom_ok;
	logic              lcd_ok;
	logic              fmem_ok;
	logic              sys_ok;
	logic              rom_ok;

	assign wide_sync = st_ff.pin_s2[8];
	assign wr_cnt    = reg_wr & (reg_addr == ADDR_REFRESH_CNT);

	// ----------------------------------------
	// Wait decoders
	// ----------------------------------------
	// [R1] Page ROM decode
	wait_decode #(.W(2), .BASE(PROM_BASE), .STEP(PROM_STEP), .MAXC(PROM_MAX)) u_prom (
		.clock(clock), .rst(rst), .code(st_ff.page_rom_wait), .cycles(prom_cyc), .valid(prom_ok));
	// [R2] Window decode, LCD use
	wait_decode #(.W(3), .BASE(LCD_BASE), .STEP(LCD_STEP), .MAXC(LCD_MAX)) u_lcd (
		.clock(clock), .rst(rst), .code(st_ff.window_wait), .cycles(lcd_cyc), .valid(lcd_ok));
	// [R2] Window decode, fast memory use
	wait_decode #(.W(3), .BASE(FMEM_BASE), .STEP(FMEM_STEP), .MAXC(FMEM_MAX)) u_fmem (
		.clock(clock), .rst(rst), .code(st_ff.window_wait), .cycles(fmem_cyc), .valid(fmem_ok));
	// [R3] System bus decode
	wait_decode #(.W(3), .BASE(SYS_BASE), .STEP(SYS_STEP), .MAXC(SYS_MAX)) u_sys (
		.clock(clock), .rst(rst), .code(st_ff.sysbus_wait), .cycles(sysbus_wait_cycles), .valid(sys_ok));
	// [R4] Ordinary ROM decode
	wait_decode #(.W(3), .BASE(ROM_BASE), .STEP(ROM_STEP), .MAXC(ROM_MAX)) u_rom (
		.clock(clock), .rst(rst), .code(st_ff.rom_wait), .cycles(rom_cyc), .valid(rom_ok));

	// ----------------------------------------
	// Refresh counter
	// ----------------------------------------
	// [R25] Hold counts only when enabled
	assign bus_occupied = sysbus_busy | window_busy | (hold_active & hold_timeout_enable);

	refresh_counter u_rfc (
		.clock           (clock),
		.rst             (rst),
		.interval        (st_ff.interval),
		.load_en         (wr_cnt),
		.load_value      (reg_wdata[RFSH_W-1:0]),
		.refresh_done    (refresh_done),
		.bus_occupied    (bus_occupied),
		.count           (refresh_count),
		.refresh_request (refresh_request),
		.refresh_pending (refresh_pending),
		.bus_timeout     (bus_timeout)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		nxt_st = st_ff;
		// Two-stage sync of pin and straps
		nxt_st.pin_s1 = {wide_bus_mode, divide_by_two_flag, divide_by_three_flag,
			divide_by_four_flag, clock_speed_code};
		nxt_st.pin_s2 = st_ff.pin_s1;
		// [R16] First zero divider flag wins
		if (!st_ff.pin_s2[7]) begin
			nxt_st.pclk_mult = MULT_X3_DIV2;
		end else if (!st_ff.pin_s2[6]) begin
			nxt_st.pclk_mult = MULT_X3_DIV3;
		end else if (!st_ff.pin_s2[5]) begin
			nxt_st.pclk_mult = MULT_X3_DIV4;
		end else begin
			nxt_st.pclk_mult = MULT_X3_NONE;
		end
		// [R6] Writes keep only defined fields
		if (reg_wr && reg_addr == ADDR_ACCESS_WAIT) begin
			nxt_st.page_rom_wait = reg_wdata[PROM_LSB +: 2];
			nxt_st.window_wait   = reg_wdata[WIN_LSB +: 3];
			nxt_st.sysbus_wait   = reg_wdata[SYS_LSB +: 3];
			nxt_st.rom_wait      = reg_wdata[ROM_LSB +: 3];
		end
		// [R9] Refresh period store
		if (reg_wr && reg_addr == ADDR_REFRESH_INT) begin
			nxt_st.interval = reg_wdata[RFSH_W-1:0];
		end
		// [R22] Only in wide bus mode
		if (reg_wr && reg_addr == ADDR_EXPANSION_CFG && wide_sync) begin
			nxt_st.exp_rom_size  = reg_wdata[EROM_BIT];
			nxt_st.exp_dram_size = reg_wdata[EDRAM_BIT];
			nxt_st.bank_map      = reg_wdata[BMAP_LSB +: 2];
			nxt_st.exp_enable    = reg_wdata[EMEM_BIT];
			nxt_st.lcd_bus_width = reg_wdata[LCD_BUS_WIDTH_BIT];
		end
		// [R7] Write one clears
		if (reg_wr && reg_addr == ADDR_BUS_ERROR && reg_wdata[ERR_BIT]) begin
			nxt_st.bus_error_flag = 1'b0;
		end
		// [R8] [R26] Error set wins
		if (bus_error_event || bus_timeout) begin
			nxt_st.bus_error_flag = 1'b1;
		end
		// Read data stands one cycle only
		nxt_st.rdata = '0;
		if (reg_rd) begin
			case (reg_addr)
				ADDR_ACCESS_WAIT: begin
					nxt_st.rdata[PROM_LSB +: 2] = st_ff.page_rom_wait;
					nxt_st.rdata[WIN_LSB +: 3]  = st_ff.window_wait;
					nxt_st.rdata[SYS_LSB +: 3]  = st_ff.sysbus_wait;
					nxt_st.rdata[ROM_LSB +: 3]  = st_ff.rom_wait;
				end
				ADDR_BUS_ERROR: begin
					nxt_st.rdata[ERR_BIT] = st_ff.bus_error_flag;
				end
				ADDR_REFRESH_INT: begin
					nxt_st.rdata[RFSH_W-1:0] = st_ff.interval;
				end
				// [R14] Revision fields
				ADDR_REVISION: begin
					nxt_st.rdata[ID_LSB +: 4] = PROCESSOR_ID;
					nxt_st.rdata[MJ_LSB +: 4] = MAJOR_REV;
					nxt_st.rdata[MN_LSB +: 4] = MINOR_REV;
				end
				ADDR_REFRESH_CNT: begin
					nxt_st.rdata[RFSH_W-1:0] = refresh_count;
				end
				// [R17] Speed code and divider flags
				ADDR_CLOCK_RATIO: begin
					nxt_st.rdata[DIV2_BIT]      = st_ff.pin_s2[7];
					nxt_st.rdata[DIV3_BIT]      = st_ff.pin_s2[6];
					nxt_st.rdata[DIV4_BIT]      = st_ff.pin_s2[5];
					nxt_st.rdata[CLOCK_SPEED_CODE_LSB +: 5] = st_ff.pin_s2[4:0];
				end
				ADDR_EXPANSION_CFG: begin
					nxt_st.rdata[EROM_BIT]      = st_ff.exp_rom_size;
					nxt_st.rdata[EDRAM_BIT]     = st_ff.exp_dram_size;
					nxt_st.rdata[BMAP_LSB +: 2] = st_ff.bank_map;
					nxt_st.rdata[EMEM_BIT]      = st_ff.exp_enable;
					nxt_st.rdata[LCD_BUS_WIDTH_BIT]     = st_ff.lcd_bus_width;
				end
				default: begin
					nxt_st.rdata = '0;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge clock) begin
		if (rst) begin
			st_ff          <= '0;
			st_ff.interval <= INTERVAL_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign reg_rdata      = st_ff.rdata;
	assign bus_error_flag = st_ff.bus_error_flag;
	// [R5] [R24] Page ROM wait only where enabled
	assign rom_bank0_wait = page_rom_enable[0] ? prom_cyc : rom_cyc;
	assign rom_bank1_wait = page_rom_enable[1] ? prom_cyc : rom_cyc;
	// [R23] Window steering
	assign window_wait_cycles = window_select ? fmem_cyc : lcd_cyc;
	assign wait_codes_valid   = prom_ok & rom_ok & sys_ok & (window_select ? fmem_ok : lcd_ok);
	// [R18] Size selects
	assign expansion_rom_size  = st_ff.exp_rom_size;
	assign expansion_dram_size = st_ff.exp_dram_size;
	// [R19] Bank map decode
	assign bank3_is_rom   = (st_ff.bank_map == BMAP_ALL_ROM) | (st_ff.bank_map == BMAP_HI_ROM);
	assign bank2_is_rom   = (st_ff.bank_map == BMAP_ALL_ROM);
	assign bank_map_valid = st_ff.bank_map inside {BMAP_ALL_ROM, BMAP_HI_ROM, BMAP_ALL_DRAM};
	// [R20] Expansion gate
	assign expansion_access_allowed = st_ff.exp_enable;
	// [R21] LCD width; fast memory fixed narrow
	assign window_data_width = (!window_select && st_ff.lcd_bus_width) ? WIDTH_WIDE : WIDTH_NARROW;
	assign peripheral_clock_mult_x3 = st_ff.pclk_mult;
	assign core_clock_mult          = CORE_MULT;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	// Register port, error flag, refresh counter and wait decode checks
	a_err_set_event: assert property (bus_error_event |=> bus_error_flag) // [R8]
		else $error("bus error did not set flag");
	a_err_w1c_clear: assert property ( // [R7]
		(reg_wr && reg_addr == ADDR_BUS_ERROR && reg_wdata[ERR_BIT] && !bus_error_event && !bus_timeout)
		|=> !bus_error_flag) else $error("write one did not clear flag");
	a_err_set_wins: assert property ( // [R26]
		(reg_wr && reg_addr == ADDR_BUS_ERROR && reg_wdata[ERR_BIT] && bus_error_event)
		|=> bus_error_flag) else $error("error lost to clear");
	a_rfc_reload: assert property ((refresh_count == '0 && !wr_cnt) // [R10]
		|=> refresh_count == $past(st_ff.interval)) else $error("counter not reloaded");
	a_rfc_count_down: assert property ((refresh_count != '0 && !wr_cnt) // [R11]
		|=> refresh_count == $past(refresh_count) - RFSH_W'(1)) else $error("counter not counting");
	a_timeout_cause: assert property (bus_timeout |-> // [R12]
		refresh_request && refresh_pending && (sysbus_busy || window_busy || (hold_active && hold_timeout_enable)))
		else $error("timeout without cause");
	a_rev_fields: assert property ((reg_rd && reg_addr == ADDR_REVISION) |=> // [R14]
		reg_rdata == {PROCESSOR_ID, MAJOR_REV, 4'h0, MINOR_REV}) else $error("revision read wrong");
	a_wait_reserved: assert property ((reg_rd && reg_addr == ADDR_ACCESS_WAIT) |=> // [R6]
		(reg_rdata & 16'hC888) == 16'h0000) else $error("reserved bits not zero");
	a_exp_locked: assert property ((reg_wr && reg_addr == ADDR_EXPANSION_CFG && !wide_sync) // [R22]
		|=> $stable(st_ff.exp_enable) && $stable(st_ff.bank_map)) else $error("expansion written in narrow mode");
	a_rom_wait_dec: assert property ((!$past(rst) && !page_rom_enable[0] && $stable(st_ff.rom_wait)) // [R4]
		|-> rom_bank0_wait == WAIT_W'(ROM_BASE - int'(st_ff.rom_wait))) else $error("rom wait decode wrong");
	// Refresh, timeout, error register and fast memory width checks
	a_interval_store: assert property ((reg_wr && reg_addr == ADDR_REFRESH_INT) // [R9]
		|=> st_ff.interval == $past(reg_wdata[RFSH_W-1:0])) else $error("interval not stored");
	a_timeout_sets_err: assert property (bus_timeout |=> bus_error_flag) // [R8]
		else $error("timeout did not set flag");
	a_hold_gated: assert property ((hold_active && !hold_timeout_enable && !sysbus_busy && !window_busy) // [R25]
		|-> !bus_timeout) else $error("timeout during unchecked hold");
	a_err_reg_zero: assert property ((reg_rd && reg_addr == ADDR_BUS_ERROR) // [R6]
		|=> reg_rdata[DATA_W-1:1] == '0) else $error("error register reserved bits set");
	a_fmem_narrow: assert property (window_select |-> window_data_width == WIDTH_NARROW) // [R21]
		else $error("fast memory width not narrow");

	c_timeout: cover property (bus_timeout);
	c_err_clear: cover property (bus_error_flag ##1 !bus_error_flag);
	c_refresh_served: cover property (refresh_request ##[1:8] refresh_done);
	c_exp_write: cover property (reg_wr && reg_addr == ADDR_EXPANSION_CFG && wide_sync);
	c_hold_timeout: cover property (bus_timeout && hold_active && !sysbus_busy);
endmodule
`default_nettype wire

// [verif/test_bus_timing_refresh_config_regs.sv]
// Self-checking bench for the bus timing, refresh and configuration registers.
// Assumes the design package is compiled first; the bench drives every port.
`timescale 1ns/1ps
`default_nettype none
module test_bus_timing_refresh_config_regs;
	import bcu_cfg_pkg::*;
	typedef struct {logic [15:0] wd; logic pre; logic ws; logic [3:0] b0, b1, win, sys;} row_s;
	logic        clock, rst, reg_wr, reg_rd, bus_error_event, sysbus_busy, window_busy, hold_active;
	logic        refresh_done, window_select, hold_timeout_enable, wide_bus_mode, refresh_request;
	logic        divide_by_two_flag, divide_by_three_flag, divide_by_four_flag, bus_timeout;
	logic        bus_error_flag, wait_codes_valid, bank3_is_rom, bank2_is_rom, expansion_access_allowed;
	logic        expansion_rom_size, expansion_dram_size, bank_map_valid;
	logic [31:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	logic [1:0]  page_rom_enable;
	logic [4:0]  clock_speed_code;
	logic [3:0]  rom_bank0_wait, rom_bank1_wait, window_wait_cycles, sysbus_wait_cycles;
	logic [5:0]  window_data_width;
	logic [6:0]  peripheral_clock_mult_x3, core_clock_mult;
	int          bad_count, total_checks, cyc, n;
	row_s        rows[5] = '{'{16'h2000, 1, 0, 1, 9, 8, 8}, '{16'h2000, 0, 0, 9, 1, 8, 8},
		'{16'h0357, 1, 1, 3, 2, 5, 3}, '{16'h0357, 0, 0, 2, 3, 2, 3}, '{16'h1726, 0, 1, 3, 2, 1, 6}};

	// Design under test
	bus_timing_refresh_config_regs dut_u (.clock, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .bus_error_event, .sysbus_busy, .window_busy, .hold_active, .refresh_done,
		.window_select, .page_rom_enable, .hold_timeout_enable, .wide_bus_mode, .clock_speed_code,
		.divide_by_two_flag, .divide_by_three_flag, .divide_by_four_flag, .rom_bank0_wait,
		.rom_bank1_wait, .window_wait_cycles, .sysbus_wait_cycles, .wait_codes_valid,
		.refresh_request, .bus_timeout, .bus_error_flag, .expansion_rom_size,
		.expansion_dram_size, .bank3_is_rom, .bank2_is_rom, .bank_map_valid,
		.expansion_access_allowed, .window_data_width, .peripheral_clock_mult_x3, .core_clock_mult);

	// -----------------------------
	// Clock, timeout and helpers
	// -----------------------------
	initial begin
		clock = 0;
		forever #4 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc++;
		if (cyc == 6000) begin
			bad_count++;
			give_verdict();
		end
	end
	task give_verdict;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	// One-cycle write strobe
	task wr(input logic [31:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 0;
	endtask
	// Read, data sampled in the following cycle only
	task rdc(input logic [31:0] a, input logic [15:0] e);
		@(posedge clock);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 0;
		#1 chk(reg_rdata, e);
	endtask
	// Edges until the next refresh request, bounded
	task wait_req;
		n = 0;
		do begin
			@(posedge clock);
			#1 n++;
		end while (refresh_request !== 1'b1 && n < 600);
	endtask

	// -----------------------------
	// Main sequence
	// -----------------------------
	initial begin
		{rst, reg_wr, reg_rd, bus_error_event, sysbus_busy, window_busy, hold_active} = 7'h01 << 6;
		{refresh_done, window_select, hold_timeout_enable, wide_bus_mode, divide_by_three_flag} = 0;
		{divide_by_two_flag, divide_by_four_flag, clock_speed_code, page_rom_enable} = 9'h1A8;
		{reg_addr, reg_wdata, bad_count, total_checks, cyc} = 0;
		repeat (10) @(posedge clock);
		rst <= 0;
		rdc(ADDR_REFRESH_INT, 16'h0200);
		wr(ADDR_REVISION, 16'hFFFF);
		rdc(ADDR_REVISION, 16'h5100);
		rdc(32'h0B000002, 16'h0000);
		chk(bus_error_flag, 0);
		foreach (rows[i]) begin
			@(posedge clock);
			page_rom_enable <= {~rows[i].pre, rows[i].pre};
			window_select <= rows[i].ws;
			wr(ADDR_ACCESS_WAIT, rows[i].wd);
			repeat (2) @(posedge clock);
			#1 chk({rom_bank0_wait, rom_bank1_wait, window_wait_cycles, sysbus_wait_cycles},
				{rows[i].b0, rows[i].b1, rows[i].win, rows[i].sys});
		end
		wr(ADDR_ACCESS_WAIT, 16'hFFFF);
		rdc(ADDR_ACCESS_WAIT, 16'h3777);
		chk(wait_codes_valid, 0);
		chk(peripheral_clock_mult_x3, 7'h40);
		chk(core_clock_mult, 7'h40);
		rdc(ADDR_CLOCK_RATIO, 16'hA00A);
		// Expansion register only writable in wide mode
		wr(ADDR_EXPANSION_CFG, 16'hFFFF);
		rdc(ADDR_EXPANSION_CFG, 16'h0000);
		wide_bus_mode <= 1;
		repeat (3) @(posedge clock);
		wr(ADDR_EXPANSION_CFG, 16'hFFFF);
		rdc(ADDR_EXPANSION_CFG, 16'hF880);
		chk({bank3_is_rom, bank2_is_rom, expansion_access_allowed, window_data_width}, 9'h1D0);
		window_select <= 0;
		#8 chk({expansion_rom_size, expansion_dram_size, bank_map_valid, window_data_width}, 9'h1E0);
		wr(ADDR_EXPANSION_CFG, 16'h2000);
		#1 chk({bank3_is_rom, bank2_is_rom, expansion_access_allowed, expansion_rom_size, expansion_dram_size},
			5'b10000);
		wr(ADDR_EXPANSION_CFG, 16'h1000);
		#1 chk(bank_map_valid, 0);
		// Error flag set, clear, and set beating clear
		bus_error_event <= 1;
		@(posedge clock);
		bus_error_event <= 0;
		rdc(ADDR_BUS_ERROR, 16'h0001);
		wr(ADDR_BUS_ERROR, 16'h0001);
		#1 chk(bus_error_flag, 0);
		@(posedge clock);
		{bus_error_event, reg_wr, reg_addr, reg_wdata} <= {2'b11, ADDR_BUS_ERROR, 16'h0001};
		@(posedge clock);
		{bus_error_event, reg_wr} <= 0;
		#1 chk(bus_error_flag, 1);
		wr(ADDR_BUS_ERROR, 16'h0001);
		// Refresh reload, load and timeout while system bus busy
		wr(ADDR_REFRESH_INT, 16'hC002);
		rdc(ADDR_REFRESH_INT, 16'h0002);
		sysbus_busy <= 1;
		wr(ADDR_REFRESH_CNT, 16'h0003);
		wait_req;
		chk(n, 3);
		chk(bus_timeout, 1);
		// Serve the refresh one cycle after the new request
		@(posedge clock);
		refresh_done <= 1;
		@(posedge clock);
		refresh_done <= 0;
		wait_req;
		chk(bus_timeout, 0);
		wait_req;
		chk(n, 3);
		chk(bus_error_flag, 1);
		// Bus hold only times out with its enable set
		sysbus_busy <= 0;
		hold_active <= 1;
		wait_req;
		chk(bus_timeout, 0);
		hold_timeout_enable <= 1;
		#1 chk(bus_timeout, 1);
		give_verdict();
	end
endmodule
`default_nettype wire
